// ### design/mset_params.svh
// Constants for the mode settings register block
`ifndef MSET_PARAMS_SVH
`define MSET_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define MSET_ADDR_W         6
`define MSET_ADDR_MODE      6'h11
`define MSET_RESET_MODE     8'h3b
`define MSET_RDATA_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Field positions inside the mode settings register
// ----------------------------------------------------------------
`define MSET_BIT_CRC_ORDER  7
`define MSET_BIT_SYNC_DET   6
`define MSET_BIT_TX_WAIT    5
`define MSET_BIT_RX_WAIT    4
`define MSET_BIT_ENV_POL    3
`define MSET_BIT_MDET_OFF   2
`define MSET_SEED_HI        1
`define MSET_SEED_LO        0

// ----------------------------------------------------------------
// CRC seed values and sync byte
// ----------------------------------------------------------------
`define MSET_SEED_00        16'h0000
`define MSET_SEED_01        16'h6363
`define MSET_SEED_10        16'ha671
`define MSET_SEED_11        16'h0000
`define MSET_SYNC_BYTE      8'hf0
`define MSET_RXW_W          6

`endif

// ### design/mset_pkg.sv
// Types shared by the mode settings register block
package mset_pkg;

  // Operating mode of the frontend, one-hot
  typedef enum logic [3:0] {
    OPM_READER    = 4'h1,
    OPM_INITIATOR = 4'h2,
    OPM_TARGET    = 4'h4,
    OPM_CARD      = 4'h8
  } mset_opmode_t;

  // Sync hunt state of the receiver gate
  typedef enum logic [1:0] {
    SYN_HUNT = 2'h1,
    SYN_OPEN = 2'h2
  } mset_sync_t;

  // Receive wait counter state
  typedef enum logic [2:0] {
    RXW_IDLE  = 3'h1,
    RXW_ARMED = 3'h2,
    RXW_COUNT = 3'h4
  } mset_rxw_t;

endpackage

// ### design/mset_cfg_if.sv
// Configuration carrier from the register to its helper modules
`timescale 1ns/1ps
interface mset_cfg_if;
  logic       crc_bit_order;            // CRC computed msb first
  logic [1:0] crc_seed_select;          // Stand-alone CRC seed choice
  logic       envelope_input_polarity;  // 1: pin active high
  logic       rf_comm;                  // RF communication in progress

  modport owner (
    output crc_bit_order,
    output crc_seed_select,
    output envelope_input_polarity,
    output rf_comm
  );
  modport crc (
    input crc_bit_order,
    input crc_seed_select,
    input rf_comm
  );
  modport env (
    input envelope_input_polarity
  );
endinterface

// ### design/mset_env_cond.sv
// Envelope input pin conditioning and activity event
`timescale 1ns/1ps
`include "mset_params.svh"
module mset_env_cond (
  input  wire logic mclk,                // System clock
  input  wire logic srst,                // Synchronous reset
  input  wire logic envelope_input_pin,  // Raw pin, asynchronous
  mset_cfg_if.env   cfg,                 // Polarity setting
  output logic      env_internal_n,      // Internal envelope, active low
  output logic      env_activity         // One-cycle activity event
);

  logic sync1_ff;  // First synchroniser stage
  logic sync2_ff;  // Second synchroniser stage
  logic prev_ff;   // Last seen synchronised level
  logic pol_ff;    // Last seen polarity setting

  // Two-stage synchroniser for the pin
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= envelope_input_pin;
      sync2_ff <= sync1_ff;
    end
  end

  // Edge and polarity-change history, internal envelope level
  always_ff @(posedge mclk) begin
    if (srst) begin
      prev_ff        <= 1'b0;
      pol_ff         <= 1'(`MSET_RESET_MODE >> `MSET_BIT_ENV_POL);
      env_internal_n <= 1'b1;
      env_activity   <= 1'b0;
    end else begin
      prev_ff <= sync2_ff;
      pol_ff  <= cfg.envelope_input_polarity;
      // Pin read per polarity, internal copy always low active
      env_internal_n <= ~(cfg.envelope_input_polarity ? sync2_ff : ~sync2_ff);
      // A polarity flip counts as an input transition
      env_activity <= (sync2_ff != prev_ff) |
                      (cfg.envelope_input_polarity != pol_ff);
    end
  end

endmodule

// ### design/mset_crc_cfg.sv
// CRC seed and bit order selection for the CRC co-processor
`timescale 1ns/1ps
`include "mset_params.svh"
module mset_crc_cfg (
  input  wire logic        mclk,           // System clock
  input  wire logic        srst,           // Synchronous reset
  mset_cfg_if.crc          cfg,            // Register fields
  input  wire logic        proto_msb_first,// Order the active protocol needs
  input  wire logic [15:0] rf_crc_seed,    // Seed derived from framing
  input  wire logic [15:0] crc_raw,        // Raw engine result
  output logic             crc_msb_first,  // Order handed to the engine
  output logic [15:0]      crc_seed,       // Seed handed to the engine
  output logic [7:0]       crc_result_high,// Result high byte
  output logic [7:0]       crc_result_low  // Result low byte
);

  logic [15:0] seed_sel;  // Seed picked by the register field
  logic [15:0] raw_rev;   // Each result byte bit reversed

  // Seed lookup for the stand-alone CRC command
  always_comb begin
    unique case (cfg.crc_seed_select)
      2'h0:    seed_sel = `MSET_SEED_00;
      2'h1:    seed_sel = `MSET_SEED_01;
      2'h2:    seed_sel = `MSET_SEED_10;
      default: seed_sel = `MSET_SEED_11;
    endcase
  end

  // Bit reversal within each result byte
  genvar i;
  for (i = 0; i < 8; i++) begin : g_rev
    assign raw_rev[i]     = crc_raw[7 - i];
    assign raw_rev[8 + i] = crc_raw[15 - i];
  end

  // Registered outputs; RF traffic overrides the register fields
  always_ff @(posedge mclk) begin
    if (srst) begin
      crc_msb_first   <= 1'b0;
      crc_seed        <= `MSET_SEED_00;
      crc_result_high <= 8'h00;
      crc_result_low  <= 8'h00;
    end else begin
      crc_msb_first <= cfg.rf_comm ? proto_msb_first : cfg.crc_bit_order;
      crc_seed      <= cfg.rf_comm ? rf_crc_seed : seed_sel;
      if (cfg.crc_bit_order && !cfg.rf_comm) begin
        crc_result_high <= raw_rev[15:8];
        crc_result_low  <= raw_rev[7:0];
      end else begin
        crc_result_high <= crc_raw[15:8];
        crc_result_low  <= crc_raw[7:0];
      end
    end
  end

endmodule

// ### design/mset_top.sv
// Mode settings register and the mode gating it drives
//
// Summary of operation
// - 8-bit RW register at 11h, reset 3Bh
// - Bit 7 set: CRC msb first, result bits reversed within each byte outside RF traffic
// - During RF traffic protocol decides CRC order
// - Sync on: hunt F0h, prepend F0h
// - Bit 5: transmitter waits for own field in reader and initiator modes
// - Bit 4: receive wait waits for external field in target and card modes
// - Bit 3 sets envelope pin polarity
// - Internal envelope always active low
// - Polarity change raises envelope activity event
// - Bit 2 switches mode detector off
// - Mode detector runs only during anticollision
// - Seed field: 00 0000, 01 6363, 10 A671
// - RF traffic picks CRC seed from framing
`timescale 1ns/1ps
`include "mset_params.svh"
module mset_top (
  // ---------------------------------------------------------------
  // Clock and reset
  // ---------------------------------------------------------------
  input  wire logic                   mclk,               // System clock
  input  wire logic                   srst,               // Synchronous reset
  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  input  wire logic [`MSET_ADDR_W-1:0] reg_addr,          // Register address
  input  wire logic                   reg_wr_en,          // Write strobe
  input  wire logic [7:0]             reg_wdata,          // Write data
  input  wire logic                   reg_rd_en,          // Read strobe
  output logic      [7:0]             reg_rdata,          // Read data
  output logic                        reg_rvalid,         // Read data valid
  // ---------------------------------------------------------------
  // Operating state of the frontend
  // ---------------------------------------------------------------
  input  mset_pkg::mset_opmode_t      op_mode,            // Operating mode
  input  wire logic                   rf_comm,            // RF traffic active
  input  wire logic                   own_field_on,       // Own field generated
  input  wire logic                   ext_field_det,      // External field seen
  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  input  wire logic                   tx_start_req,       // Start request
  output logic                        tx_start_ok,        // Start granted
  output logic                        tx_sync_prepend,    // Prepend sync byte
  output logic      [7:0]             tx_sync_byte,       // Sync byte value
  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  input  wire logic                   rx_frame_start,     // New frame begins
  input  wire logic                   rx_byte_valid,      // Received byte strobe
  input  wire logic [7:0]             rx_byte,            // Received byte
  output logic                        rx_enable,          // Receiver active
  input  wire logic                   rx_wait_arm,        // Start receive wait
  input  wire logic                   bit_tick,           // Bit-rate enable
  input  wire logic [`MSET_RXW_W-1:0] rx_wait_bits,       // Wait length in bits
  output logic                        rx_wait_busy,       // Wait armed or counter running
  output logic                        rx_wait_done,       // Wait over, one cycle
  // ---------------------------------------------------------------
  // Envelope input
  // ---------------------------------------------------------------
  input  wire logic                   envelope_input_pin, // Envelope pin
  output logic                        env_internal_n,     // Envelope, active low
  output logic                        envelope_activity_irq, // Activity event
  // ---------------------------------------------------------------
  // Mode detector
  // ---------------------------------------------------------------
  input  wire logic                   auto_anticoll_active, // Anticollision runs
  output logic                        mode_det_enable,    // Detector switched on
  // ---------------------------------------------------------------
  // CRC co-processor
  // ---------------------------------------------------------------
  input  wire logic                   proto_msb_first,    // Protocol bit order
  input  wire logic [15:0]            rf_crc_seed,        // Framing-derived seed
  input  wire logic [15:0]            crc_raw,            // Raw CRC result
  output logic                        crc_msb_first,      // Engine bit order
  output logic      [15:0]            crc_seed,           // Engine seed
  output logic      [7:0]             crc_result_high,    // Result high byte
  output logic      [7:0]             crc_result_low      // Result low byte
);

  // ---------------------------------------------------------------
  // Register storage and decode
  // ---------------------------------------------------------------
  logic [7:0] mode_settings_ff;   // Mode settings register
  logic       hit;                // Access targets this register

  // Named views of the fields
  logic       crc_bit_order;            // Bit 7
  logic       sync_detect;              // Bit 6
  logic       tx_wait_for_field;        // Bit 5
  logic       rx_wait_for_field;        // Bit 4
  logic       mode_detector_disable;    // Bit 2

  assign hit = (reg_addr == `MSET_ADDR_MODE);

  assign crc_bit_order         = mode_settings_ff[`MSET_BIT_CRC_ORDER];
  assign sync_detect           = mode_settings_ff[`MSET_BIT_SYNC_DET];
  assign tx_wait_for_field     = mode_settings_ff[`MSET_BIT_TX_WAIT];
  assign rx_wait_for_field     = mode_settings_ff[`MSET_BIT_RX_WAIT];
  assign mode_detector_disable = mode_settings_ff[`MSET_BIT_MDET_OFF];

  // Register write; every bit is writable
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_settings_ff <= `MSET_RESET_MODE;
    end else if (reg_wr_en && hit) begin
      mode_settings_ff <= reg_wdata;
    end
  end

  // Register read; other addresses answer zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= hit ? mode_settings_ff : `MSET_RDATA_UNMAPPED;
      end
    end
  end

  // ---------------------------------------------------------------
  // Configuration carrier to the helper modules
  // ---------------------------------------------------------------
  mset_cfg_if cfg ();

  assign cfg.crc_bit_order           = crc_bit_order;
  assign cfg.crc_seed_select         = mode_settings_ff[`MSET_SEED_HI:`MSET_SEED_LO];
  assign cfg.envelope_input_polarity = mode_settings_ff[`MSET_BIT_ENV_POL];
  assign cfg.rf_comm                 = rf_comm;

  // ---------------------------------------------------------------
  // Transmitter gating
  // ---------------------------------------------------------------
  logic tx_field_mode;  // Mode in which the own field matters

  assign tx_field_mode = (op_mode == mset_pkg::OPM_READER) ||
                         (op_mode == mset_pkg::OPM_INITIATOR);

  // Hold back a start until the own field is up
  assign tx_start_ok = tx_start_req &&
                       (!tx_wait_for_field || !tx_field_mode || own_field_on);

  // Sync byte insertion follows the register bit; the host keeps it
  // clear outside 106 kbit peer-to-peer exchange
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_sync_prepend <= 1'b0;
      tx_sync_byte    <= `MSET_SYNC_BYTE;
    end else begin
      tx_sync_prepend <= sync_detect;
      tx_sync_byte    <= `MSET_SYNC_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // Receiver sync hunt
  // ---------------------------------------------------------------
  mset_pkg::mset_sync_t sync_st_ff;   // Hunt state
  mset_pkg::mset_sync_t nxt_sync_st;  // Next hunt state

  // A new frame restarts the hunt; the sync byte opens the receiver
  always_comb begin
    nxt_sync_st = sync_st_ff;
    unique case (sync_st_ff)
      mset_pkg::SYN_HUNT: begin
        if (rx_byte_valid && (rx_byte == `MSET_SYNC_BYTE)) begin
          nxt_sync_st = mset_pkg::SYN_OPEN;
        end
      end
      mset_pkg::SYN_OPEN: begin
        if (rx_frame_start) begin
          nxt_sync_st = mset_pkg::SYN_HUNT;
        end
      end
      default: nxt_sync_st = mset_pkg::SYN_HUNT;
    endcase
  end

  // Hunt state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_st_ff <= mset_pkg::SYN_HUNT;
    end else begin
      sync_st_ff <= nxt_sync_st;
    end
  end

  // Receiver is free unless sync handling is on
  always_ff @(posedge mclk) begin
    if (srst) begin
      rx_enable <= 1'b1;
    end else begin
      rx_enable <= !sync_detect || (nxt_sync_st == mset_pkg::SYN_OPEN);
    end
  end

  // ---------------------------------------------------------------
  // Receive wait counter
  // ---------------------------------------------------------------
  mset_pkg::mset_rxw_t    rxw_st_ff;   // Counter state
  mset_pkg::mset_rxw_t    nxt_rxw_st;  // Next counter state
  logic [`MSET_RXW_W-1:0] rxw_cnt_ff;  // Bits left to wait
  logic                   rx_field_mode; // Mode in which the field matters
  logic                   rxw_last;    // Final bit of the wait

  assign rx_field_mode = (op_mode == mset_pkg::OPM_TARGET) ||
                         (op_mode == mset_pkg::OPM_CARD);
  assign rxw_last      = bit_tick && (rxw_cnt_ff <= `MSET_RXW_W'(1));

  // Arm, wait for the external field where required, then count
  always_comb begin
    nxt_rxw_st = rxw_st_ff;
    unique case (rxw_st_ff)
      mset_pkg::RXW_IDLE: begin
        if (rx_wait_arm) begin
          if (rx_wait_for_field && rx_field_mode && !ext_field_det) begin
            nxt_rxw_st = mset_pkg::RXW_ARMED;
          end else begin
            nxt_rxw_st = mset_pkg::RXW_COUNT;
          end
        end
      end
      mset_pkg::RXW_ARMED: begin
        if (ext_field_det) begin
          nxt_rxw_st = mset_pkg::RXW_COUNT;
        end
      end
      mset_pkg::RXW_COUNT: begin
        if (rxw_last) begin
          nxt_rxw_st = mset_pkg::RXW_IDLE;
        end
      end
      default: nxt_rxw_st = mset_pkg::RXW_IDLE;
    endcase
  end

  // Counter state, count and outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxw_st_ff    <= mset_pkg::RXW_IDLE;
      rxw_cnt_ff   <= '0;
      rx_wait_done <= 1'b0;
    end else begin
      rxw_st_ff    <= nxt_rxw_st;
      rx_wait_done <= (rxw_st_ff == mset_pkg::RXW_COUNT) && rxw_last;
      if (rxw_st_ff == mset_pkg::RXW_IDLE) begin
        rxw_cnt_ff <= rx_wait_bits;
      end else if (rxw_st_ff == mset_pkg::RXW_COUNT && bit_tick) begin
        rxw_cnt_ff <= rxw_cnt_ff - `MSET_RXW_W'(1);
      end
    end
  end

  assign rx_wait_busy = (rxw_st_ff != mset_pkg::RXW_IDLE);

  // ---------------------------------------------------------------
  // Mode detector enable
  // ---------------------------------------------------------------
  // Only during anticollision, and only if not switched off
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_det_enable <= 1'b0;
    end else begin
      mode_det_enable <= auto_anticoll_active && !mode_detector_disable;
    end
  end

  // ---------------------------------------------------------------
  // Helper modules
  // ---------------------------------------------------------------
  // Envelope pin synchroniser, polarity and activity event
  mset_env_cond u_env (
    .mclk               (mclk),
    .srst               (srst),
    .envelope_input_pin (envelope_input_pin),
    .cfg                (cfg.env),
    .env_internal_n     (env_internal_n),
    .env_activity       (envelope_activity_irq)
  );

  // CRC order, seed and result presentation
  mset_crc_cfg u_crc (
    .mclk            (mclk),
    .srst            (srst),
    .cfg             (cfg.crc),
    .proto_msb_first (proto_msb_first),
    .rf_crc_seed     (rf_crc_seed),
    .crc_raw         (crc_raw),
    .crc_msb_first   (crc_msb_first),
    .crc_seed        (crc_seed),
    .crc_result_high (crc_result_high),
    .crc_result_low  (crc_result_low)
  );

endmodule

// ### verif/mset_top_asserts.sv
// Checker for the mode settings register block
`timescale 1ns/1ps
`include "mset_params.svh"
module mset_top_asserts (
  input  wire logic        mclk,                  // Clock
  input  wire logic        srst,                  // Reset
  input  wire logic [5:0]  reg_addr,              // Address
  input  wire logic        reg_wr_en,             // Write
  input  wire logic [7:0]  reg_wdata,             // Write data
  input  wire logic        reg_rd_en,             // Read
  input  wire logic [7:0]  reg_rdata,             // Read data
  input  wire logic        reg_rvalid,            // Read valid
  input  mset_pkg::mset_opmode_t op_mode,         // Mode
  input  wire logic        rf_comm,               // RF traffic
  input  wire logic        own_field_on,          // Own field
  input  wire logic        tx_start_req,          // Tx request
  input  wire logic        tx_start_ok,           // Tx grant
  input  wire logic        auto_anticoll_active,  // Anticollision
  input  wire logic        mode_det_enable,       // Detector on
  input  wire logic        envelope_activity_irq, // Activity
  input  wire logic        proto_msb_first,       // Protocol order
  input  wire logic [15:0] rf_crc_seed,           // Framing seed
  input  wire logic [15:0] crc_raw,               // Raw result
  input  wire logic        crc_msb_first,         // Engine order
  input  wire logic [15:0] crc_seed,              // Engine seed
  input  wire logic [7:0]  crc_result_high        // Result high
);
  // ----------------------------------------------------------------
  // Shadow of the register and derived expectations
  // ----------------------------------------------------------------
  logic [7:0]  shd_ff;   // Expected register contents
  logic        wr_hit;   // Write to the mapped register
  logic        mdet_exp; // Detector should run
  logic [15:0] seed_exp; // Seed selected by the field
  logic [7:0]  rev_hi;   // High raw byte reversed
  assign wr_hit = reg_wr_en && (reg_addr == `MSET_ADDR_MODE);
  assign mdet_exp = auto_anticoll_active && !shd_ff[2];
  // Follow host writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      shd_ff <= 8'h3b;
    end else if (wr_hit) begin
      shd_ff <= reg_wdata;
    end
  end
  // Seed table and byte reversal
  always_comb begin
    case (shd_ff[1:0])
      2'h1: seed_exp = 16'h6363;
      2'h2: seed_exp = 16'ha671;
      2'h3: seed_exp = `MSET_SEED_11;
      default: seed_exp = 16'h0000;
    endcase
    for (int k = 0; k < 8; k++) rev_hi[k] = crc_raw[15-k];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  AST_RVALID: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered");
  AST_RDBACK: assert property (wr_hit ##1 (reg_rd_en && reg_addr == 6'h11)
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("read back wrong");
  AST_TXGATE: assert property (tx_start_ok == (tx_start_req && (!shd_ff[5]
    || own_field_on || !(op_mode inside {mset_pkg::OPM_READER, mset_pkg::OPM_INITIATOR}))))
    else $error("tx grant wrong");
  AST_MDET: assert property (!$past(srst) |-> mode_det_enable == $past(mdet_exp))
    else $error("detector enable wrong");
  AST_ACTPOL: assert property (wr_hit && reg_wdata[3] != shd_ff[3]
    |-> ##2 envelope_activity_irq) else $error("no activity on polarity change");
  AST_SEED: assert property (!rf_comm |=> crc_seed == $past(seed_exp))
    else $error("seed wrong");
  AST_REV: assert property (!rf_comm && shd_ff[7]
    |=> crc_msb_first && crc_result_high == $past(rev_hi)) else $error("reversal wrong");
  AST_CRCRF: assert property (rf_comm |=> crc_msb_first == $past(proto_msb_first)
    && crc_seed == $past(rf_crc_seed)) else $error("rf crc choice wrong");
endmodule
bind mset_top mset_top_asserts u_mset_top_asserts (.*);

// ### verif/testbench.sv
// Self-checking bench for the mode settings register block
`timescale 1ns/1ps
`include "mset_params.svh"
module testbench;
  logic        mclk, srst, reg_wr_en, reg_rd_en, rf_comm, own_field_on, ext_field_det;
  logic        tx_start_req, rx_frame_start, rx_byte_valid, rx_wait_arm, bit_tick;
  logic        envelope_input_pin, auto_anticoll_active, proto_msb_first, reg_rvalid;
  logic        tx_start_ok, tx_sync_prepend, rx_enable, rx_wait_busy, rx_wait_done;
  logic        env_internal_n, envelope_activity_irq, mode_det_enable, crc_msb_first;
  logic [5:0]  reg_addr, rx_wait_bits;
  logic [7:0]  reg_wdata, rx_byte, reg_rdata, tx_sync_byte, crc_result_high, crc_result_low;
  logic [15:0] rf_crc_seed, crc_raw, crc_seed;
  mset_pkg::mset_opmode_t op_mode;
  int          fail_count, tests_run, seed, mreg, i, n;
  mset_top u_mset_top (.*);
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    #800000;
    fail_count++;
    close_out();
  end
  // Compare one result
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    tick(1);
    reg_wr_en = 1'b0;
    if (a == 6'h11) mreg = d;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    tick(1);
    reg_rd_en = 1'b0;
    chk("rvalid", 16'h1, reg_rvalid);
    chk("rdata", exp, reg_rdata);
  endtask
  // Receive one byte, then look at the receiver gate
  task automatic rxb(logic [7:0] b, logic exp);
    rx_byte = b;
    rx_byte_valid = 1'b1;
    tick(1);
    rx_byte_valid = 1'b0;
    tick(1);
    chk("rx_enable", exp, rx_enable);
  endtask
  function automatic logic [7:0] rev(logic [7:0] b);
    for (int k = 0; k < 8; k++) rev[k] = b[7-k];
  endfunction
  function automatic logic [15:0] exp_seed(int s);
    case (s)
      1: return 16'h6363;
      2: return 16'ha671;
      3: return `MSET_SEED_11;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {reg_wr_en, reg_rd_en, rf_comm, own_field_on, ext_field_det, tx_start_req} = '0;
    {rx_frame_start, rx_byte_valid, rx_wait_arm, bit_tick, envelope_input_pin} = '0;
    {auto_anticoll_active, proto_msb_first, reg_addr, rx_wait_bits, reg_wdata} = '0;
    {rx_byte, rf_crc_seed, crc_raw} = '0;
    op_mode = mset_pkg::OPM_READER;
    seed = 32'h2685;
    mreg = 8'h3b;
    srst = 1'b1;
    tick(16);
    srst = 1'b0;
    rd(6'h11, 8'h3b);
    tick(1);
    rd(6'h05, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(6'h11, 8'($random(seed)));
      rd(6'h11, mreg[7:0]);
    end
    wr(6'h12, 8'hff);
    rd(6'h11, mreg[7:0]);
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      wr(6'h11, {i[2], 5'h00, i[1:0]});
      crc_raw = 16'($random(seed));
      rf_crc_seed = 16'($random(seed));
      proto_msb_first = !i[2];
      rf_comm = 1'b0;
      tick(2);
      chk("seed", exp_seed(i % 4), crc_seed);
      chk("order", i[2], crc_msb_first);
      chk("res_hi", i[2] ? rev(crc_raw[15:8]) : crc_raw[15:8], crc_result_high);
      chk("res_lo", i[2] ? rev(crc_raw[7:0]) : crc_raw[7:0], crc_result_low);
      rf_comm = 1'b1;
      tick(2);
      chk("rf_seed", rf_crc_seed, crc_seed);
      chk("rf_order", proto_msb_first, crc_msb_first);
    end
    rf_comm = 1'b0;
    $display("crc test done");
    for (i = 0; i < 16; i++) begin
      wr(6'h11, {2'h0, i[3], 5'h00});
      op_mode = mset_pkg::mset_opmode_t'(4'h1 << i[1:0]);
      own_field_on = i[2];
      tx_start_req = 1'b1;
      tick(1);
      chk("tx_ok", !(i[3] && i[1:0] < 2 && !i[2]), tx_start_ok);
    end
    tx_start_req = 1'b0;
    $display("transmit gate test done");
    op_mode = mset_pkg::OPM_INITIATOR;
    wr(6'h11, 8'h40);
    rx_frame_start = 1'b1;
    tick(1);
    rx_frame_start = 1'b0;
    rxb(8'h55, 1'b0);
    chk("sync_on", 16'h1, tx_sync_prepend);
    chk("sync_byte", 16'hf0, tx_sync_byte);
    rxb(8'hf0, 1'b1);
    wr(6'h11, 8'h00);
    rxb(8'h00, 1'b1);
    chk("sync_off", 16'h0, tx_sync_prepend);
    $display("sync test done");
    wr(6'h11, 8'h10);
    op_mode = mset_pkg::OPM_TARGET;
    rx_wait_bits = 6'd3;
    rx_wait_arm = 1'b1;
    tick(1);
    rx_wait_arm = 1'b0;
    chk("rxw_busy", 16'h1, rx_wait_busy);
    n = 0;
    for (i = 1; i < 21; i++) begin
      if (i == 11) ext_field_det = 1'b1;
      bit_tick = i[0];
      tick(1);
      if (rx_wait_done === 1'b1 && n == 0) n = i;
    end
    chk("rxw_ticks", 16'd17, n[15:0]);
    $display("receive wait test done");
    for (i = 0; i < 4; i++) begin
      wr(6'h11, {4'h0, i[1], 3'h0});
      envelope_input_pin = i[0];
      tick(4);
      chk("env", i[1] ? !i[0] : i[0], env_internal_n);
    end
    for (i = 0; i < 2; i++) begin
      wr(6'h11, 8'h00);
      n = 0;
      repeat (4) begin
        tick(1);
        n += int'(envelope_activity_irq === 1'b1);
      end
      chk("activity", 16'(1 - i), n[15:0]);
    end
    for (i = 0; i < 4; i++) begin
      wr(6'h11, {5'h00, i[1], 2'h0});
      auto_anticoll_active = i[0];
      tick(2);
      chk("mdet", i[0] && !i[1], mode_det_enable);
    end
    $display("envelope and detector test done");
    close_out();
  end
endmodule
